// ### rtl/hbs_pkg.sv
// holds the constants and state type of the host bus strobe and address front end
// assumes one clock domain (mclk) and an asynchronous active-low reset
package hbs_pkg;

  // ****************************************************************
  // widths of the host port
  // ****************************************************************
  localparam int unsigned HBS_ADDR_W = 11;
  localparam int unsigned HBS_DATA_W = 8;

  // ****************************************************************
  // bundle of pins passed through the synchroniser
  // ****************************************************************
  localparam int unsigned HBS_SYNC_W   = 24;
  localparam int unsigned HBS_POS_MODE = 23;  // bus_mode_select
  localparam int unsigned HBS_POS_CSN  = 22;  // chip_select_n
  localparam int unsigned HBS_POS_STB  = 21;  // addr_strobe_n / async_write_n pin
  localparam int unsigned HBS_POS_CTL  = 20;  // sync_write_not_read / async_read_n pin
  localparam int unsigned HBS_POS_CLK  = 19;  // host_bus_clock
  localparam int unsigned HBS_POS_ADDR = 8;   // host_addr lsb
  localparam int unsigned HBS_POS_DATA = 0;   // host_data_in lsb
  // strobes, select and control idle high, everything else low
  localparam logic [23:0] HBS_SYNC_RST = 24'h700000;

  // ****************************************************************
  // mode encodings and reset values
  // ****************************************************************
  localparam logic        HBS_MODE_SYNC  = 1'h1;
  localparam logic        HBS_MODE_ASYNC = 1'h0;
  localparam logic [10:0] HBS_RST_ADDR   = 11'h000;
  localparam logic [7:0]  HBS_RST_DATA   = 8'h00;

  // ****************************************************************
  // access sequencer states
  // ****************************************************************
  typedef enum logic [2:0] {
    HBS_IDLE   = 3'b001,
    HBS_READ   = 3'b010,
    HBS_AWRITE = 3'b100
  } hbs_state_e;

endpackage : hbs_pkg

// ### rtl/hbs_sync.sv
// holds a two flip-flop synchroniser for a bundle of pin inputs
// assumes the bits are independent levels; multi-bit buses must be stable around strobes
module hbs_sync
  import hbs_pkg::*;
#(
  parameter int unsigned        WIDTH   = HBS_SYNC_W,
  parameter logic [WIDTH-1:0]   RST_VAL = '0
) (
  input  wire logic             mclk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_sync
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] sync_nxt;

  // first stage feeds only the second stage
  always_comb begin
    meta_nxt = pin_in;
    sync_nxt = meta_r;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      meta_r <= RST_VAL;
      sync_r <= RST_VAL;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign pin_sync = sync_r;

endmodule // hbs_sync

// ### rtl/hbs_port.sv
// holds the host register port front end: strobe decode, address capture, read drive
// assumes all host pins are asynchronous to mclk and the register file answers
// reg_rdata combinationally from reg_addr
//
// Function
// - synchronous accesses are accepted only while the address strobe is low
// - asynchronous mode uses the dual pin as active-low write strobe for data
// - asynchronous write needs chip select low, read strobe high, reset inactive
// - the 11-bit host address selects the internal register accessed
// - mode select high picks synchronous mode, low picks asynchronous mode
// - synchronous write-not-read high writes, low reads and drives the data bus
// - asynchronous read strobe low drives the addressed register onto the bus
// - chip select high ignores clock and strobes and floats the data bus
module hbs_port
  import hbs_pkg::*;
(
  input  wire logic                  mclk,
  input  wire logic                  resetn,
  input  wire logic                  bus_mode_select,
  input  wire logic                  chip_select_n,
  input  wire logic                  addr_strobe_n,
  input  wire logic                  sync_write_not_read,
  input  wire logic                  host_bus_clock,
  input  wire logic [HBS_ADDR_W-1:0] host_addr,
  input  wire logic [HBS_DATA_W-1:0] host_data_in,
  output logic      [HBS_DATA_W-1:0] host_data_out,
  output logic                       host_data_oe_n,
  output logic      [HBS_ADDR_W-1:0] reg_addr,
  output logic      [HBS_DATA_W-1:0] reg_wdata,
  output logic                       reg_wr,
  output logic                       reg_rd,
  input  wire logic [HBS_DATA_W-1:0] reg_rdata
);

  // ****************************************************************
  // pin synchronisation
  // ****************************************************************
  logic [HBS_SYNC_W-1:0] pins_raw;
  logic [HBS_SYNC_W-1:0] pins_s;

  // one bundle keeps every pin at the same two-cycle latency
  assign pins_raw = {bus_mode_select, chip_select_n, addr_strobe_n, sync_write_not_read,
                     host_bus_clock, host_addr, host_data_in};

  hbs_sync #(
    .WIDTH   (HBS_SYNC_W),
    .RST_VAL (HBS_SYNC_RST)
  ) u_sync (
    .mclk     (mclk),
    .resetn   (resetn),
    .pin_in   (pins_raw),
    .pin_sync (pins_s)
  );

  logic                  s_mode;
  logic                  s_cs_n;
  logic                  s_as_n;
  logic                  s_wr_n;
  logic                  s_wnr;
  logic                  s_rd_n;
  logic                  s_clk;
  logic [HBS_ADDR_W-1:0] s_addr;
  logic [HBS_DATA_W-1:0] s_data;

  // the two dual-purpose pins carry a different meaning per mode
  assign s_mode = pins_s[HBS_POS_MODE];
  assign s_cs_n = pins_s[HBS_POS_CSN];
  assign s_as_n = pins_s[HBS_POS_STB];
  assign s_wr_n = pins_s[HBS_POS_STB];
  assign s_wnr  = pins_s[HBS_POS_CTL];
  assign s_rd_n = pins_s[HBS_POS_CTL];
  assign s_clk  = pins_s[HBS_POS_CLK];
  assign s_addr = pins_s[HBS_POS_ADDR +: HBS_ADDR_W];
  assign s_data = pins_s[HBS_POS_DATA +: HBS_DATA_W];

  // ****************************************************************
  // access decode
  // ****************************************************************
  logic clk_prev_r;
  logic clk_prev_nxt;
  logic clk_rise;
  logic sync_sel;
  logic sync_wr_hit;
  logic async_wr_start;
  logic async_wr_ok;
  logic rd_act;

  // host clock is slow against mclk, so its edge is found on the synced level
  assign clk_rise = s_clk & ~clk_prev_r;
  // selected and address strobe low: the only window a sync access is seen
  assign sync_sel = (s_mode == HBS_MODE_SYNC) & ~s_cs_n & ~s_as_n;
  assign sync_wr_hit = sync_sel & s_wnr & clk_rise;
  // async write begins on strobe low with read strobe idle
  assign async_wr_start = (s_mode == HBS_MODE_ASYNC) & ~s_cs_n & s_rd_n & ~s_wr_n;
  // commit condition checked at the trailing edge of the write strobe
  assign async_wr_ok = (s_mode == HBS_MODE_ASYNC) & ~s_cs_n & s_rd_n & s_wr_n;
  // read is a level; a held write strobe blocks an async read
  always_comb begin
    if (s_mode == HBS_MODE_SYNC) begin
      rd_act = sync_sel & ~s_wnr;
    end else begin
      rd_act = ~s_cs_n & ~s_rd_n & s_wr_n;
    end
  end

  // ****************************************************************
  // access sequencer
  // ****************************************************************
  hbs_state_e            state_r;
  hbs_state_e            state_nxt;
  logic [HBS_ADDR_W-1:0] reg_addr_r;
  logic [HBS_ADDR_W-1:0] reg_addr_nxt;
  logic [HBS_DATA_W-1:0] reg_wdata_r;
  logic [HBS_DATA_W-1:0] reg_wdata_nxt;
  logic                  reg_wr_r;
  logic                  reg_wr_nxt;
  logic                  reg_rd_r;
  logic                  reg_rd_nxt;

  // next state, address, write data and strobes
  always_comb begin
    state_nxt     = state_r;
    reg_addr_nxt  = reg_addr_r;
    reg_wdata_nxt = reg_wdata_r;
    reg_wr_nxt    = 1'h0;
    reg_rd_nxt    = 1'h0;
    clk_prev_nxt  = s_clk;
    unique case (state_r)
      HBS_IDLE: begin
        if (rd_act) begin
          state_nxt    = HBS_READ;
          reg_addr_nxt = s_addr;
          reg_rd_nxt   = 1'h1;
        end else if (sync_wr_hit) begin
          reg_addr_nxt  = s_addr;
          reg_wdata_nxt = s_data;
          reg_wr_nxt    = 1'h1;
        end else if (async_wr_start) begin
          state_nxt     = HBS_AWRITE;
          reg_addr_nxt  = s_addr;
          reg_wdata_nxt = s_data;
        end
      end
      HBS_READ: begin
        if (rd_act) begin
          reg_addr_nxt = s_addr;
          reg_rd_nxt   = 1'h1;
        end else begin
          state_nxt = HBS_IDLE;
        end
      end
      HBS_AWRITE: begin
        if (async_wr_start) begin
          // keep the latest values while the strobe stays low
          reg_addr_nxt  = s_addr;
          reg_wdata_nxt = s_data;
        end else if (rd_act) begin
          // a read strobe meeting the strobe release drops the write and reads at once
          state_nxt    = HBS_READ;
          reg_addr_nxt = s_addr;
          reg_rd_nxt   = 1'h1;
        end else begin
          // commit on the rising strobe only; an abort drops the write
          state_nxt  = HBS_IDLE;
          reg_wr_nxt = async_wr_ok;
        end
      end
      default: begin
        state_nxt = HBS_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_r     <= HBS_IDLE;
      reg_addr_r  <= HBS_RST_ADDR;
      reg_wdata_r <= HBS_RST_DATA;
      reg_wr_r    <= 1'h0;
      reg_rd_r    <= 1'h0;
      clk_prev_r  <= 1'h0;
    end else begin
      state_r     <= state_nxt;
      reg_addr_r  <= reg_addr_nxt;
      reg_wdata_r <= reg_wdata_nxt;
      reg_wr_r    <= reg_wr_nxt;
      reg_rd_r    <= reg_rd_nxt;
      clk_prev_r  <= clk_prev_nxt;
    end
  end

  // ****************************************************************
  // read data drive
  // ****************************************************************
  logic [HBS_DATA_W-1:0] data_out_r;
  logic [HBS_DATA_W-1:0] data_out_nxt;
  logic                  data_oe_n_r;
  logic                  data_oe_n_nxt;

  // bus driven only once the addressed value is registered; floats when deselected
  always_comb begin
    data_out_nxt  = data_out_r;
    data_oe_n_nxt = ~(reg_rd_r & rd_act);
    if (reg_rd_r) begin
      data_out_nxt = reg_rdata;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      data_out_r  <= HBS_RST_DATA;
      data_oe_n_r <= 1'h1;
    end else begin
      data_out_r  <= data_out_nxt;
      data_oe_n_r <= data_oe_n_nxt;
    end
  end

  assign host_data_out  = data_out_r;
  assign host_data_oe_n = data_oe_n_r;
  assign reg_addr       = reg_addr_r;
  assign reg_wdata      = reg_wdata_r;
  assign reg_wr         = reg_wr_r;
  assign reg_rd         = reg_rd_r;

  // ****************************************************************
  // assertions
  // ****************************************************************
  a_sync_wr_qual: assert property (@(posedge mclk) disable iff (!resetn)
    reg_wr_r && $past(s_mode) && $past(state_r) == HBS_IDLE
      |-> $past(~s_cs_n && ~s_as_n && s_wnr))
    else $error("sync write without strobe qualification");

  a_async_wr_commit: assert property (@(posedge mclk) disable iff (!resetn)
    state_r == HBS_AWRITE && s_wr_n && !s_mode && !s_cs_n && s_rd_n
      |=> reg_wr_r && reg_wdata_r == $past(reg_wdata_r))
    else $error("async write not committed at strobe release");

  a_async_wr_block: assert property (@(posedge mclk) disable iff (!resetn)
    state_r == HBS_AWRITE && (s_cs_n || !s_rd_n) |=> !reg_wr_r)
    else $error("async write committed without select or with read");

  a_addr_capture: assert property (@(posedge mclk) disable iff (!resetn)
    rd_act |=> reg_rd_r && reg_addr_r == $past(s_addr))
    else $error("read address not captured");

  a_mode_select: assert property (@(posedge mclk) disable iff (!resetn)
    !s_mode && state_r == HBS_IDLE |=> !reg_wr_r)
    else $error("async write bypassed strobe sequencing");

  a_sync_wr_pulse: assert property (@(posedge mclk) disable iff (!resetn)
    state_r == HBS_IDLE && s_mode && clk_rise && !s_cs_n && !s_as_n && s_wnr
      |=> reg_wr_r && reg_wdata_r == $past(s_data) ##1 !reg_wr_r)
    else $error("sync write pulse wrong");

  a_read_drive: assert property (@(posedge mclk) disable iff (!resetn)
    rd_act ##1 rd_act |=> !host_data_oe_n && host_data_out == $past(reg_rdata))
    else $error("read data not driven");

  a_deselect_quiet: assert property (@(posedge mclk) disable iff (!resetn)
    s_cs_n |=> host_data_oe_n && !reg_wr_r)
    else $error("activity while deselected");

  c_sync_write: cover property (@(posedge mclk) disable iff (!resetn) reg_wr_r && s_mode);
  c_async_write: cover property (@(posedge mclk) disable iff (!resetn) reg_wr_r && !s_mode);
  c_sync_read: cover property (@(posedge mclk) disable iff (!resetn)
    !host_data_oe_n && s_mode);
  c_async_read: cover property (@(posedge mclk) disable iff (!resetn)
    !host_data_oe_n && !s_mode);

endmodule // hbs_port

// ### bench/hbs_host_model.sv
// holds a behavioural model of the external host driving the register port pins
// assumes the bench calls its tasks in sequence and supplies mclk at 20 MHz
module hbs_host_model (
  input  wire logic        mclk,
  output logic             mode,
  output logic             cs_n,
  output logic             stb_n,
  output logic             ctl,
  output logic             hclk,
  output logic [10:0]      addr,
  output logic [7:0]       dout,
  output logic             drv
);
  timeunit 1ns;
  timeprecision 1ns;

  // ****************************************************************
  // pin drivers
  // ****************************************************************
  // idle: deselected, strobes high, host clock standing still low
  initial begin
    {mode, cs_n, stb_n, ctl, hclk, drv} = 6'b011100;
    addr = 11'h000;
    dout = 8'h00;
  end

  // all pins but the host clock move together just after an edge; strobe low only with a valid address
  task automatic pins(input logic m, c, s, t, input logic [10:0] a,
                      input logic [7:0] d, input logic dr);
    @(posedge mclk);
    #5;
    mode  = m;
    cs_n  = c;
    stb_n = s;
    ctl   = t;
    addr  = a;
    dout  = d;
    drv   = dr;
  endtask

  // one host clock rise, 3 mclk low then 3 mclk high, so pins lead the rise
  task automatic hrise();
    repeat (3) @(posedge mclk);
    #5 hclk = 1'b1;
    repeat (3) @(posedge mclk);
    #5 hclk = 1'b0;
  endtask
endmodule // hbs_host_model

// ### bench/tb_host_bus_strobe_and_address.sv
// holds the self-checking bench of the host port front end
// assumes hbs_pkg is compiled first; the register file is modelled as a pattern
module tb_host_bus_strobe_and_address;
  import hbs_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  // ****************************************************************
  // clock, reset and wiring
  // ****************************************************************
  logic        mclk = 1'b0;
  logic        resetn = 1'b0;
  logic        mode, cs_n, stb_n, ctl, hclk, drv, oe_n, wr, rd;
  logic [10:0] haddr, raddr;
  logic [7:0]  hdout, din, dout, wdata, rdata;
  logic [10:0] wa;
  logic [7:0]  wd;
  int          wcnt = 0;
  int          num_errors = 0;
  int          checked = 0;

  always #25 mclk = ~mclk;

  // register file answers combinationally with a pattern of the address
  assign rdata = raddr[7:0] ^ 8'h5A;
  // released bus shows the inverse of the host's last value, not a stale copy
  assign din = drv ? hdout : (!oe_n ? dout : ~hdout);

  hbs_host_model host (
    .mclk (mclk), .mode (mode), .cs_n (cs_n), .stb_n (stb_n), .ctl (ctl),
    .hclk (hclk), .addr (haddr), .dout (hdout), .drv (drv)
  );

  hbs_port dut (
    .mclk (mclk), .resetn (resetn), .bus_mode_select (mode), .chip_select_n (cs_n),
    .addr_strobe_n (stb_n), .sync_write_not_read (ctl), .host_bus_clock (hclk),
    .host_addr (haddr), .host_data_in (din), .host_data_out (dout),
    .host_data_oe_n (oe_n), .reg_addr (raddr), .reg_wdata (wdata),
    .reg_wr (wr), .reg_rd (rd), .reg_rdata (rdata)
  );

  // counts every write pulse and keeps the address and data of the last one so scenarios can inspect it
  always @(posedge mclk) begin
    if (wr === 1'b1) begin
      wcnt++;
      wa = raddr;
      wd = wdata;
    end
  end

  // ****************************************************************
  // checking and closing
  // ****************************************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  // synchronous write on a host clock rise, qualified by select and strobe
  task automatic sync_wr(input logic c, s, input logic [10:0] a, input logic [7:0] d);
    int n0;
    n0 = wcnt;
    host.pins(1'b1, c, s, 1'b1, a, d, 1'b1);
    host.hrise();
    repeat (4) @(posedge mclk);
    check(16'(wcnt - n0), {15'h0000, !c && !s});
    if (!c && !s) begin
      check({5'h00, wa}, {5'h00, a});
      check({8'h00, wd}, {8'h00, d});
    end
    host.pins(1'b1, 1'b1, 1'b1, 1'b1, a, d, 1'b0);
  endtask

  // asynchronous write, committed on strobe release; read strobe falling mid-strobe aborts it
  task automatic async_wr(input logic r, input logic [10:0] a, input logic [7:0] d);
    int n0;
    n0 = wcnt;
    host.pins(1'b0, 1'b0, 1'b0, 1'b1, a, d, 1'b1);
    repeat (2) @(posedge mclk);
    host.pins(1'b0, 1'b0, 1'b0, r, a, d, 1'b1);
    host.pins(1'b0, 1'b0, 1'b1, r, a, d, 1'b1);
    // one spare edge so the pulse counter has settled before it is read
    repeat (5) @(posedge mclk);
    check(16'(wcnt - n0), {15'h0000, r});
    if (r) begin
      check({5'h00, wa}, {5'h00, a});
      check({8'h00, wd}, {8'h00, d});
    end
    host.pins(1'b0, 1'b1, 1'b1, 1'b1, a, d, 1'b0);
  endtask

  // read in either mode, then deselect and see the bus float again
  task automatic read(input logic m, input logic [10:0] a);
    host.pins(m, 1'b0, !m, 1'b0, a, 8'h00, 1'b0);
    repeat (5) @(posedge mclk);
    check({7'h00, rd, oe_n}, 16'h0002);
    check({8'h00, dout}, {8'h00, a[7:0] ^ 8'h5A});
    host.pins(m, 1'b1, !m, 1'b0, a, 8'h00, 1'b0);
    repeat (4) @(posedge mclk);
    check({7'h00, rd, oe_n}, 16'h0001);
  endtask

  // ****************************************************************
  // main sequence and watchdog
  // ****************************************************************
  initial begin
    repeat (20) @(posedge mclk);
    #5 resetn = 1'b1;
    check({6'h00, wr, oe_n}, 16'h0001);
    sync_wr(1'b0, 1'b0, 11'h7FF, 8'hA5);
    sync_wr(1'b0, 1'b0, 11'h001, 8'h3C);
    sync_wr(1'b0, 1'b1, 11'h2AA, 8'h11);
    sync_wr(1'b1, 1'b0, 11'h555, 8'h22);
    read(1'b1, 11'h4C3);
    async_wr(1'b1, 11'h400, 8'hFF);
    async_wr(1'b0, 11'h123, 8'h77);
    async_wr(1'b1, 11'h0F0, 8'h81);
    read(1'b0, 11'h7E1);
    results();
  end

  // cuts a hang short well beyond the 123 or so cycles the scenarios need
  initial begin
    repeat (5000) @(posedge mclk);
    num_errors++;
    results();
  end
endmodule // tb_host_bus_strobe_and_address
